// [rtl/dcil_defines.vh]
// Notes on behaviour
// - a 1 written to enable-set low/high sets that enable bit; 0 leaves it
// - a 1 written to enable-clear low/high clears that enable bit; 0 leaves it
// - enable pair is read-only, changed only through set and clear registers
// - channel with completion irq option returns its completion code on completion
// - completion code n sets pending bit n, low half 0-31, high half 32-63
// - a set pending bit stays set until software clears it
// - pending halves read-only; 1 means code detected, 0 never seen or cleared
// - a 1 written to pending-clear low/high clears that pending bit; 0 no effect
// - reevaluate register exists globally and per shadow region, never gated
// - reevaluate bit 0 written 1 pulses interrupt if enabled pending bit set
// - reevaluate pulse goes to the interrupt of the copy that was written
`ifndef DCIL_DEFINES_VH
`define DCIL_DEFINES_VH

// ***********************************************
// register byte offsets
// ***********************************************
`define DCIL_OFS_ENA_LO 8'h00
`define DCIL_OFS_ENA_HI 8'h04
`define DCIL_OFS_ENA_CLR_LO 8'h08
`define DCIL_OFS_ENA_CLR_HI 8'h0C
`define DCIL_OFS_ENA_SET_LO 8'h10
`define DCIL_OFS_ENA_SET_HI 8'h14
`define DCIL_OFS_PEND_LO 8'h18
`define DCIL_OFS_PEND_HI 8'h1C
`define DCIL_OFS_PEND_CLR_LO 8'h20
`define DCIL_OFS_PEND_CLR_HI 8'h24
`define DCIL_OFS_REEVAL 8'h28
`define DCIL_OFS_IRQ_STAT 8'h30
`define DCIL_OFS_IRQ_MASK 8'h34
`define DCIL_OFS_SHADOW_BASE 8'h40
`define DCIL_SHADOW_STRIDE 8'h04

// ***********************************************
// field positions and reset values
// ***********************************************
`define DCIL_REEVAL_BIT 0
`define DCIL_CODE_HALF_BIT 5
`define DCIL_EV_NEW_PEND 0
`define DCIL_EV_DUP_CODE 1
`define DCIL_EV_REEVAL 2
`define DCIL_EV_WIDTH 3
`define DCIL_RST_HALF 32'h0000_0000
`define DCIL_RST_EV 3'h0
`define DCIL_RDATA_ZERO 32'h0000_0000

`endif

// [rtl/dcil_top.v]
`timescale 1ns/1ps
`include "dcil_defines.vh"

module dcil_top #(
   parameter NUM_REGIONS = 4,
   parameter ADDR_WIDTH = 8
) (
   input wire MCLK_I,
   input wire RST_N_I,
   input wire [ADDR_WIDTH-1:0] AVS_ADDRESS_I,
   input wire AVS_READ_I,
   input wire AVS_WRITE_I,
   input wire [31:0] AVS_WRITEDATA_I,
   input wire [3:0] AVS_BYTEENABLE_I,
   output wire [31:0] AVS_READDATA_O,
   output wire AVS_WAITREQUEST_O,
   input wire TC_DONE_VALID_I,
   input wire [5:0] TC_COMPLETION_CODE_I,
   input wire EARLY_DONE_VALID_I,
   input wire [5:0] EARLY_COMPLETION_CODE_I,
   output wire COMP_INT_LEVEL_O,
   output wire COMP_INT_PULSE_O,
   output wire [NUM_REGIONS-1:0] REGION_INT_PULSE_O,
   output wire IRQ_O
);

   // ***********************************************
   // bus slave: one wait state on every access
   // ***********************************************
   reg ack_q;
   reg [31:0] rdata_q;
   reg [31:0] rdata_d;
   wire req = AVS_READ_I | AVS_WRITE_I;
   wire wr_acc = AVS_WRITE_I & ack_q;
   wire rd_acc = AVS_READ_I & ack_q;
   wire [31:0] be_mask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                          {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
   wire [31:0] wdata = AVS_WRITEDATA_I & be_mask;

   assign AVS_WAITREQUEST_O = req & ~ack_q;
   assign AVS_READDATA_O = rdata_q;

   always @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // ***********************************************
   // write decode, plus the status read decode
   // ***********************************************
   wire hit_ena_clr_lo = wr_acc && (AVS_ADDRESS_I == `DCIL_OFS_ENA_CLR_LO);
   wire hit_ena_clr_hi = wr_acc && (AVS_ADDRESS_I == `DCIL_OFS_ENA_CLR_HI);
   wire hit_ena_set_lo = wr_acc && (AVS_ADDRESS_I == `DCIL_OFS_ENA_SET_LO);
   wire hit_ena_set_hi = wr_acc && (AVS_ADDRESS_I == `DCIL_OFS_ENA_SET_HI);
   wire hit_pend_clr_lo = wr_acc && (AVS_ADDRESS_I == `DCIL_OFS_PEND_CLR_LO);
   wire hit_pend_clr_hi = wr_acc && (AVS_ADDRESS_I == `DCIL_OFS_PEND_CLR_HI);
   wire hit_reeval = wr_acc && (AVS_ADDRESS_I == `DCIL_OFS_REEVAL);
   wire hit_mask = wr_acc && (AVS_ADDRESS_I == `DCIL_OFS_IRQ_MASK);
   wire stat_rd = rd_acc && (AVS_ADDRESS_I == `DCIL_OFS_IRQ_STAT);

   // ***********************************************
   // enable pair, only reachable through set/clear
   // ***********************************************
   reg [31:0] ena_lo_q;
   reg [31:0] ena_hi_q;
   reg [31:0] ena_lo_d;
   reg [31:0] ena_hi_d;

   always @* begin
      ena_lo_d = ena_lo_q;
      ena_hi_d = ena_hi_q;
      // clear first so that a set in the same write burst is not undone
      if (hit_ena_clr_lo) begin
         ena_lo_d = ena_lo_d & ~wdata;
      end
      if (hit_ena_clr_hi) begin
         ena_hi_d = ena_hi_d & ~wdata;
      end
      if (hit_ena_set_lo) begin
         ena_lo_d = ena_lo_d | wdata;
      end
      if (hit_ena_set_hi) begin
         ena_hi_d = ena_hi_d | wdata;
      end
   end

   always @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ena_lo_q <= `DCIL_RST_HALF;
         ena_hi_q <= `DCIL_RST_HALF;
      end else begin
         ena_lo_q <= ena_lo_d;
         ena_hi_q <= ena_hi_d;
      end
   end

   // ***********************************************
   // completion code capture
   // ***********************************************
   // both sources may report in one cycle; each sets its own bit
   reg [63:0] code_hits;
   integer k;
   always @* begin
      code_hits = 64'h0000_0000_0000_0000;
      for (k = 0; k < 64; k = k + 1) begin
         if (TC_DONE_VALID_I && (TC_COMPLETION_CODE_I == k[5:0])) begin
            code_hits[k] = 1'b1;
         end
         if (EARLY_DONE_VALID_I && (EARLY_COMPLETION_CODE_I == k[5:0])) begin
            code_hits[k] = 1'b1;
         end
      end
   end

   // ***********************************************
   // pending pair
   // ***********************************************
   reg [63:0] pend_q;
   wire [63:0] pend_clr = {(hit_pend_clr_hi ? wdata : 32'h0000_0000),
                           (hit_pend_clr_lo ? wdata : 32'h0000_0000)};
   // set wins over a clear in the same cycle; no hardware clear exists
   wire [63:0] pend_d = (pend_q & ~pend_clr) | code_hits;

   always @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pend_q <= {`DCIL_RST_HALF, `DCIL_RST_HALF};
      end else begin
         pend_q <= pend_d;
      end
   end

   // ***********************************************
   // completion interrupt
   // ***********************************************
   wire [63:0] live = pend_q & {ena_hi_q, ena_lo_q};
   wire any_live = |live;
   wire any_pend = |pend_q;
   reg any_pend_q;
   reg any_live_q;
   reg glob_pulse_q;
   reg [NUM_REGIONS-1:0] reg_pulse_q;

   assign COMP_INT_LEVEL_O = any_live;
   assign COMP_INT_PULSE_O = glob_pulse_q;
   assign REGION_INT_PULSE_O = reg_pulse_q;

   // edge only when the pending set turns from empty to live; while any bit
   // stays pending no fresh edge comes, so the handler must reevaluate
   wire new_edge = any_live & ~any_live_q & ~any_pend_q;
   wire glob_reevaluate_trigger = hit_reeval & AVS_WRITEDATA_I[`DCIL_REEVAL_BIT] &
                    AVS_BYTEENABLE_I[0];

   always @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         any_pend_q <= 1'b0;
         any_live_q <= 1'b0;
         glob_pulse_q <= 1'b0;
      end else begin
         any_pend_q <= any_pend;
         any_live_q <= any_live;
         glob_pulse_q <= new_edge | (glob_reevaluate_trigger & any_live);
      end
   end

   // shadow copies decode on their own, never behind region access enables
   wire [NUM_REGIONS-1:0] reg_reevaluate_trigger;
   genvar r;
   generate
      for (r = 0; r < NUM_REGIONS; r = r + 1) begin : g_region
         localparam [31:0] REG_OFS_W =
            `DCIL_OFS_SHADOW_BASE + r * `DCIL_SHADOW_STRIDE;
         assign reg_reevaluate_trigger[r] = wr_acc && (AVS_ADDRESS_I == REG_OFS_W[ADDR_WIDTH-1:0]) &&
                              AVS_WRITEDATA_I[`DCIL_REEVAL_BIT] &&
                              AVS_BYTEENABLE_I[0];
         always @(posedge MCLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
               reg_pulse_q[r] <= 1'b0;
            end else begin
               reg_pulse_q[r] <= reg_reevaluate_trigger[r] & any_live;
            end
         end
      end
   endgenerate

   // ***********************************************
   // block event status, mask and irq line
   // ***********************************************
   reg [`DCIL_EV_WIDTH-1:0] ev_stat_q;
   reg [`DCIL_EV_WIDTH-1:0] ev_mask_q;
   wire [`DCIL_EV_WIDTH-1:0] ev_set;
   assign ev_set[`DCIL_EV_NEW_PEND] = |(code_hits & ~pend_q);
   assign ev_set[`DCIL_EV_DUP_CODE] = |(code_hits & pend_q);
   assign ev_set[`DCIL_EV_REEVAL] = glob_reevaluate_trigger | (|reg_reevaluate_trigger);

   always @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ev_stat_q <= `DCIL_RST_EV;
         ev_mask_q <= `DCIL_RST_EV;
      end else begin
         // set wins over the read that clears
         ev_stat_q <= (stat_rd ? `DCIL_RST_EV : ev_stat_q) | ev_set;
         if (hit_mask) begin
            ev_mask_q <= AVS_WRITEDATA_I[`DCIL_EV_WIDTH-1:0];
         end
      end
   end

   assign IRQ_O = |(ev_stat_q & ev_mask_q);

   // ***********************************************
   // read mux, sampled in the wait cycle
   // ***********************************************
   always @* begin
      rdata_d = `DCIL_RDATA_ZERO;
      if (AVS_ADDRESS_I == `DCIL_OFS_ENA_LO) begin
         rdata_d = ena_lo_q;
      end else if (AVS_ADDRESS_I == `DCIL_OFS_ENA_HI) begin
         rdata_d = ena_hi_q;
      end else if (AVS_ADDRESS_I == `DCIL_OFS_PEND_LO) begin
         rdata_d = pend_q[31:0];
      end else if (AVS_ADDRESS_I == `DCIL_OFS_PEND_HI) begin
         rdata_d = pend_q[63:32];
      end else if (AVS_ADDRESS_I == `DCIL_OFS_IRQ_STAT) begin
         rdata_d = {29'h000_0000, ev_stat_q};
      end else if (AVS_ADDRESS_I == `DCIL_OFS_IRQ_MASK) begin
         rdata_d = {29'h000_0000, ev_mask_q};
      end
   end

   always @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rdata_q <= `DCIL_RDATA_ZERO;
      end else if (AVS_READ_I & ~ack_q) begin
         rdata_q <= rdata_d;
      end
   end

endmodule // dcil_top

// [verif/dcil_checker_properties.sv]
`timescale 1ns/1ps
module dcil_checker #(
   parameter NUM_REGIONS = 4,
   parameter ADDR_WIDTH = 8
) (
   input wire MCLK_I,
   input wire RST_N_I,
   input wire [ADDR_WIDTH-1:0] AVS_ADDRESS_I,
   input wire AVS_READ_I,
   input wire AVS_WRITE_I,
   input wire [31:0] AVS_WRITEDATA_I,
   input wire [3:0] AVS_BYTEENABLE_I,
   input wire AVS_WAITREQUEST_O,
   input wire TC_DONE_VALID_I,
   input wire EARLY_DONE_VALID_I,
   input wire COMP_INT_LEVEL_O,
   input wire COMP_INT_PULSE_O,
   input wire [NUM_REGIONS-1:0] REGION_INT_PULSE_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);
   wire acc = AVS_WRITE_I && !AVS_WAITREQUEST_O;
   wire ev = acc && AVS_WRITEDATA_I[0] && AVS_BYTEENABLE_I[0] && COMP_INT_LEVEL_O;
   wire quiet = !TC_DONE_VALID_I && !EARLY_DONE_VALID_I;
   wire cause = !quiet || acc;
   wire shadow_acc = acc && AVS_ADDRESS_I >= 8'h40;
   AST_LEVEL_HOLD: assert property (COMP_INT_LEVEL_O && !acc |=> COMP_INT_LEVEL_O)
      else $error("level dropped without a write");
   AST_LEVEL_RISE: assert property ($rose(COMP_INT_LEVEL_O) |-> $past(cause))
      else $error("level rose without cause");
   AST_ENA_RO: assert property (acc && AVS_ADDRESS_I == 8'h00 && quiet |=> $stable(COMP_INT_LEVEL_O))
      else $error("enable word written directly");
   AST_REEVALUATE_TRIGGER_GLOBAL: assert property (ev && AVS_ADDRESS_I == 8'h28 |=> COMP_INT_PULSE_O)
      else $error("no global pulse on reevaluate");
   AST_REEVALUATE_TRIGGER_SHADOW: assert property (ev && AVS_ADDRESS_I == 8'h40 |=> REGION_INT_PULSE_O[0])
      else $error("no region pulse on reevaluate");
   AST_REGION_SRC: assert property (REGION_INT_PULSE_O != 0 |-> $past(shadow_acc))
      else $error("region pulse without shadow write");
   AST_REGION_ONE: assert property (REGION_INT_PULSE_O != 0 |=> REGION_INT_PULSE_O == 0)
      else $error("region pulse too long");
   AST_READ_WAIT: assert property ($rose(AVS_READ_I) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
      else $error("read wait not one cycle");
endmodule // dcil_checker
bind dcil_top dcil_checker #(.NUM_REGIONS(NUM_REGIONS), .ADDR_WIDTH(ADDR_WIDTH)) u_chk (
   .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
   .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
   .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
   .TC_DONE_VALID_I(TC_DONE_VALID_I), .EARLY_DONE_VALID_I(EARLY_DONE_VALID_I),
   .COMP_INT_LEVEL_O(COMP_INT_LEVEL_O), .COMP_INT_PULSE_O(COMP_INT_PULSE_O),
   .REGION_INT_PULSE_O(REGION_INT_PULSE_O));

// [verif/dcil_done_model.sv]
`timescale 1ns/1ps
module dcil_done_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic send_i,
   input wire logic [5:0] code_i,
   output logic valid_o,
   output logic [5:0] code_o
);
   // code lines toggle outside a completion so a stale code never looks valid
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         valid_o <= 1'b0;
         code_o <= 6'h3F;
      end else begin
         valid_o <= send_i;
         code_o <= send_i ? code_i : ~code_o;
      end
   end
endmodule // dcil_done_model

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic avs_rd = 1'b0;
   logic avs_wr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, v;
   logic waitreq, lvl, gpulse, irq, tsend = 1'b0, esend = 1'b0, tvalid, evalid;
   logic [3:0] rpulse;
   logic [5:0] tcode = 6'h00, ecode = 6'h00, tcode_o, ecode_o;
   int n_mismatch = 0;
   int samples_checked = 0;
   int r;
   initial forever #10 clk = ~clk;
   dcil_top #(.NUM_REGIONS(4)) u_dcil_top (.MCLK_I(clk), .RST_N_I(rst_n),
      .AVS_ADDRESS_I(addr), .AVS_READ_I(avs_rd), .AVS_WRITE_I(avs_wr),
      .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata),
      .AVS_WAITREQUEST_O(waitreq), .TC_DONE_VALID_I(tvalid), .TC_COMPLETION_CODE_I(tcode_o),
      .EARLY_DONE_VALID_I(evalid), .EARLY_COMPLETION_CODE_I(ecode_o),
      .COMP_INT_LEVEL_O(lvl), .COMP_INT_PULSE_O(gpulse), .REGION_INT_PULSE_O(rpulse),
      .IRQ_O(irq));
   dcil_done_model m_tc (.clk_i(clk), .rst_n_i(rst_n), .send_i(tsend), .code_i(tcode),
      .valid_o(tvalid), .code_o(tcode_o));
   dcil_done_model m_early (.clk_i(clk), .rst_n_i(rst_n), .send_i(esend), .code_i(ecode),
      .valid_o(evalid), .code_o(ecode_o));
   // ***********************************************
   // bus, completion and compare tasks
   // ***********************************************
   task print_verdict;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   // waitrequest is sampled at each rising edge; the request stands until it is low
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      avs_wr <= w;
      avs_rd <= !w;
      addr <= a;
      wdata <= d;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (waitreq !== 1'b0 && k < 20);
      v = rdata;
      if (k >= 20) begin
         n_mismatch++;
         print_verdict;
      end
      avs_wr <= 1'b0;
      avs_rd <= 1'b0;
   endtask
   task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(n, e, v);
   endtask
   task comp(input logic vt, input logic ve, input logic [5:0] ct, input logic [5:0] ce);
      @(posedge clk);
      tsend <= vt;
      esend <= ve;
      tcode <= ct;
      ecode <= ce;
      @(posedge clk);
      tsend <= 1'b0;
      esend <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // ***********************************************
   // main sequence
   // ***********************************************
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rdchk("ena_lo", 8'h00, 32'h0);
      rdchk("pend_hi", 8'h1C, 32'h0);
      xfer(1'b1, 8'h3C, 32'hFFFF_FFFF);
      rdchk("unmapped", 8'h3C, 32'h0);
      xfer(1'b1, 8'h10, 32'h0000_0005);
      xfer(1'b1, 8'h10, 32'h0000_0002);
      xfer(1'b1, 8'h14, 32'h8000_0000);
      rdchk("ena_lo", 8'h00, 32'h0000_0007);
      rdchk("ena_hi", 8'h04, 32'h8000_0000);
      xfer(1'b1, 8'h00, 32'hFFFF_FFFF);
      xfer(1'b1, 8'h08, 32'h0000_0004);
      xfer(1'b1, 8'h0C, 32'h0);
      rdchk("ena_lo", 8'h00, 32'h0000_0003);
      rdchk("ena_hi", 8'h04, 32'h8000_0000);
      comp(1'b1, 1'b1, 6'h00, 6'h3F);
      rdchk("pend_lo", 8'h18, 32'h0000_0001);
      rdchk("pend_hi", 8'h1C, 32'h8000_0000);
      chk("level", 32'h1, lvl);
      xfer(1'b1, 8'h18, 32'hFFFF_FFFF);
      comp(1'b1, 1'b0, 6'h02, 6'h00);
      rdchk("pend_lo", 8'h18, 32'h0000_0005);
      xfer(1'b1, 8'h20, 32'h0000_0001);
      xfer(1'b1, 8'h24, 32'h8000_0000);
      rdchk("pend_lo", 8'h18, 32'h0000_0004);
      rdchk("pend_hi", 8'h1C, 32'h0);
      chk("level", 32'h0, lvl);
      xfer(1'b1, 8'h28, 32'h1);
      @(negedge clk);
      chk("reevaluate_trigger_none", 32'h0, gpulse);
      xfer(1'b1, 8'h10, 32'h0000_0004);
      xfer(1'b1, 8'h28, 32'h0);
      @(negedge clk);
      chk("reevaluate_trigger_zero", 32'h0, gpulse);
      xfer(1'b1, 8'h28, 32'h1);
      @(negedge clk);
      chk("reevaluate_trigger_one", 32'h1, gpulse);
      for (r = 0; r < 4; r++) begin
         xfer(1'b1, 8'h40 + 8'(4 * r), 32'h1);
         @(negedge clk);
         chk("region", {1'b0, 4'h1 << r}, {gpulse, rpulse});
      end
      xfer(1'b0, 8'h30, 32'h0);
      xfer(1'b1, 8'h34, 32'h0);
      comp(1'b1, 1'b0, 6'h02, 6'h00);
      chk("irq_masked", 32'h0, irq);
      xfer(1'b1, 8'h34, 32'h0000_0002);
      @(negedge clk);
      chk("irq", 32'h1, irq);
      rdchk("mask", 8'h34, 32'h0000_0002);
      rdchk("status", 8'h30, 32'h0000_0002);
      @(negedge clk);
      chk("irq_clr", 32'h0, irq);
      rdchk("pend_lo", 8'h18, 32'h0000_0004);
      // all pending bits cleared, so the next completion gives a fresh edge
      xfer(1'b1, 8'h20, 32'hFFFF_FFFF);
      comp(1'b1, 1'b0, 6'h00, 6'h00);
      @(negedge clk);
      chk("edge_fresh", 32'h1, gpulse);
      comp(1'b0, 1'b1, 6'h00, 6'h01);
      @(negedge clk);
      chk("edge_held", 32'h0, gpulse);
      rdchk("pend_lo", 8'h18, 32'h0000_0003);
      print_verdict;
   end
endmodule // tb
